// File: rtl/negate_stack_defs.vh
// Constants for the negate, idle and return-stack instruction block
`ifndef NEGATE_STACK_DEFS_VH
`define NEGATE_STACK_DEFS_VH
`define NEG_OPC_HI 7'h36
`define NEG_ACCESS_BIT 8
`define POP_WORD 16'h0006
`define PUSH_WORD 16'h0005
`define IDLE_WORD 16'h0000
`define IDLE_PREFIX 4'hf
`define LITOFF_LIMIT 8'h5f
`define PC_STEP 21'h000002
`define STACK_DEPTH 31
`define STACK_PTR_W 5
`define PC_W 21
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_BANK 4'hf
`endif

// File: rtl/negate_nop_stack_ops.v
// Executes negate, idle, pop and push instructions with four-phase cycles
`timescale 1ns/1ps
`include "negate_stack_defs.vh"
module negate_nop_stack_ops (
    input wire mclk,
    input wire rst_n,
    input wire instrValid,
    input wire [15:0] instrWord,
    input wire [20:0] pcIn,
    input wire [3:0] bankSelectReg,
    input wire extendedSet,
    input wire [11:0] indexBase,
    input wire [7:0] memRdData,
    output reg [11:0] memAddr,
    output reg memRdEn,
    output reg memWrEn,
    output reg [7:0] memWrData,
    output reg [20:0] returnStackTop,
    output reg [4:0] stackPtr,
    output reg pcAdvance,
    output reg busy
);
    localparam [3:0] ST_Q1 = 4'h1;
    localparam [3:0] ST_Q2 = 4'h2;
    localparam [3:0] ST_Q3 = 4'h4;
    localparam [3:0] ST_Q4 = 4'h8;

    // Phase and instruction state
    reg [3:0] phase_q;
    reg [3:0] phase_d;
    reg [15:0] word_q;
    reg [15:0] word_d;
    reg [7:0] data_q;
    reg [7:0] data_d;

    // Return stack storage, level 0 mirrors the visible top
    reg [20:0] stack_q [0:`STACK_DEPTH-1];

    // Next values of the output flip-flops
    reg [11:0] memAddr_d;
    reg memRdEn_d;
    reg memWrEn_d;
    reg [7:0] memWrData_d;
    reg [20:0] returnStackTop_d;
    reg [4:0] stackPtr_d;
    reg pcAdvance_d;
    reg busy_d;

    // Stack movement requests for the storage process
    reg pushNow;
    reg popNow;
    reg [20:0] pushValue;

    integer i;

    // Address formation shared by every file-operand access
    function [11:0] fileAddr;
        input [15:0] w;
        input [3:0] bank_select_reg;
        input ext;
        input [11:0] base;
        begin
            if (w[`NEG_ACCESS_BIT]) begin
                fileAddr = {bank_select_reg, w[7:0]};
            end else if (ext && (w[7:0] <= `LITOFF_LIMIT)) begin
                fileAddr = base + {4'h0, w[7:0]};
            end else if (w[7:0] < `ACCESS_SPLIT) begin
                fileAddr = {4'h0, w[7:0]};
            end else begin
                fileAddr = {`ACCESS_HIGH_BANK, w[7:0]};
            end
        end
    endfunction

    // Two's complement of one data byte
    function [7:0] negByte;
        input [7:0] d;
        begin
            negByte = ~d + 8'h01;
        end
    endfunction

    function isNegWord;
        input [15:0] w;
        begin
            isNegWord = (w[15:9] == `NEG_OPC_HI);
        end
    endfunction

    function isPopWord;
        input [15:0] w;
        begin
            isPopWord = (w == `POP_WORD);
        end
    endfunction

    function isPushWord;
        input [15:0] w;
        begin
            isPushWord = (w == `PUSH_WORD);
        end
    endfunction

    wire isNeg = isNegWord(word_q);
    wire isPop = isPopWord(word_q);
    wire isPush = isPushWord(word_q);

    always @* begin
        phase_d = phase_q;
        word_d = word_q;
        data_d = data_q;
        memAddr_d = memAddr;
        memRdEn_d = 1'h0;
        memWrEn_d = 1'h0;
        memWrData_d = memWrData;
        returnStackTop_d = returnStackTop;
        stackPtr_d = stackPtr;
        pcAdvance_d = 1'h0;
        busy_d = busy;
        pushNow = 1'h0;
        popNow = 1'h0;
        pushValue = pcIn + `PC_STEP;
        case (phase_q)
            ST_Q1: begin
                // Any other word, idle ones included, leaves state alone
                word_d = instrValid ? instrWord : `IDLE_WORD;
                busy_d = instrValid;
                phase_d = ST_Q2;
            end
            ST_Q2: begin
                if (isNeg) begin
                    memAddr_d = fileAddr(word_q, bankSelectReg,
                        extendedSet, indexBase);
                    memRdEn_d = 1'h1;
                end
                // A full stack ignores the push rather than wrap
                if (isPush && (stackPtr < `STACK_DEPTH)) begin
                    pushNow = 1'h1;
                    returnStackTop_d = pushValue;
                    stackPtr_d = stackPtr + 5'h01;
                end
                phase_d = ST_Q3;
            end
            ST_Q3: begin
                if (isNeg) begin
                    data_d = negByte(memRdData);
                end
                if (isPop && (stackPtr != 5'h00)) begin
                    // Value is dropped, never written anywhere
                    popNow = 1'h1;
                    returnStackTop_d = stack_q[1];
                    stackPtr_d = stackPtr - 5'h01;
                end
                phase_d = ST_Q4;
            end
            ST_Q4: begin
                if (isNeg) begin
                    // memAddr still holds the read address
                    memWrData_d = data_q;
                    memWrEn_d = 1'h1;
                end
                pcAdvance_d = busy;
                busy_d = 1'h0;
                phase_d = ST_Q1;
            end
            default: begin
                phase_d = ST_Q1;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            phase_q <= ST_Q1;
            word_q <= `IDLE_WORD;
            data_q <= 8'h00;
            memAddr <= 12'h000;
            memRdEn <= 1'h0;
            memWrEn <= 1'h0;
            memWrData <= 8'h00;
            returnStackTop <= 21'h000000;
            stackPtr <= 5'h00;
            pcAdvance <= 1'h0;
            busy <= 1'h0;
        end else begin
            phase_q <= phase_d;
            word_q <= word_d;
            data_q <= data_d;
            memAddr <= memAddr_d;
            memRdEn <= memRdEn_d;
            memWrEn <= memWrEn_d;
            memWrData <= memWrData_d;
            returnStackTop <= returnStackTop_d;
            stackPtr <= stackPtr_d;
            pcAdvance <= pcAdvance_d;
            busy <= busy_d;
        end
    end

    // Storage shifts as a whole so depth costs no pointer arithmetic
    always @(posedge mclk) begin
        if (!rst_n) begin
            for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
                stack_q[i] <= 21'h000000;
            end
        end else if (pushNow) begin
            // Shift down so the old top survives below
            for (i = 1; i < `STACK_DEPTH; i = i + 1) begin
                stack_q[i] <= stack_q[i-1];
            end
            stack_q[0] <= pushValue;
        end else if (popNow) begin
            for (i = 0; i < `STACK_DEPTH - 1; i = i + 1) begin
                stack_q[i] <= stack_q[i+1];
            end
            stack_q[`STACK_DEPTH-1] <= 21'h000000;
        end
    end
endmodule

// File: test/fetch_model.sv
// Fetch path model: one word per Q1 slot, idle when none is pending
`timescale 1ns/1ps
module fetch_model(input wire mclk, input wire rst_n,
    input wire [15:0] nextWord, output reg instrValid,
    output reg [15:0] instrWord);
reg [1:0] ph = 2'd0;
initial {instrValid, instrWord} = 17'h0;
always @(posedge mclk) begin
    ph <= rst_n ? ph + 2'd1 : 2'd0;
    instrValid <= rst_n && ph == 2'd3;
    // Released word toggles so stale values are never trusted
    instrWord <= (rst_n && ph == 2'd3) ? nextWord : ~instrWord;
end
endmodule

// File: test/negate_stack_checker.sv
// Timing checks for negate, idle and stack instructions
`timescale 1ns/1ps
`include "negate_stack_defs.vh"
module negate_stack_checker(input wire mclk, rst_n, instrValid, extendedSet,
    input wire [15:0] instrWord, input wire [20:0] pcIn,
    input wire [3:0] bankSelectReg, input wire [11:0] indexBase,
    input wire [7:0] memRdData, memWrData, input wire [11:0] memAddr,
    input wire memRdEn, memWrEn, pcAdvance, busy,
    input wire [20:0] returnStackTop, input wire [4:0] stackPtr);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
wire go = instrValid && !busy;
wire neg = go && instrWord[15:9] == `NEG_OPC_HI;
wire psh = go && instrWord == `PUSH_WORD && stackPtr != 5'd31;
wire pop = go && instrWord == `POP_WORD && stackPtr != 5'd0;
wire idl = go && (instrWord == 16'h0 || instrWord[15:12] == `IDLE_PREFIX);
wire acc = neg && !instrWord[8] && !extendedSet;
wire lit = neg && !instrWord[8] && extendedSet
    && instrWord[7:0] <= `LITOFF_LIMIT;
sequence s_negRead;
    ##1 busy ##1 memRdEn;
endsequence
property p_negRd;
    neg |-> s_negRead;
endproperty
a_negRd: assert property(p_negRd) else $error("negate read late");
property p_negWr;
    neg |-> s_negRead ##2
        (memWrEn && memWrData == ~$past(memRdData, 2) + 8'h01);
endproperty
a_negWr: assert property(p_negWr) else $error("negate result");
property p_sameAd;
    neg |-> ##4 memAddr == $past(memAddr, 2);
endproperty
a_sameAd: assert property(p_sameAd) else $error("write address");
property p_bank;
    neg && instrWord[8] |-> ##2
        memAddr == {$past(bankSelectReg), $past(instrWord[7:0], 2)};
endproperty
a_bank: assert property(p_bank) else $error("banked address");
property p_acc;
    acc |-> ##2 memAddr[11:8] == (($past(instrWord[7:0], 2) <
        `ACCESS_SPLIT) ? 4'h0 : `ACCESS_HIGH_BANK);
endproperty
a_acc: assert property(p_acc) else $error("access bank");
property p_litOff;
    lit |-> ##2 memAddr == $past(indexBase) + $past(instrWord[7:0], 2);
endproperty
a_litOff: assert property(p_litOff) else $error("indexed address");
property p_pushTop;
    psh |-> ##2 returnStackTop == $past(pcIn) + `PC_STEP;
endproperty
a_pushTop: assert property(p_pushTop) else $error("push value");
property p_pushDn;
    psh |-> ##2 stackPtr == $past(stackPtr, 2) + 5'd1;
endproperty
a_pushDn: assert property(p_pushDn) else $error("push depth");
property p_pop;
    pop |-> ##3 stackPtr == $past(stackPtr, 3) - 5'd1;
endproperty
a_pop: assert property(p_pop) else $error("pop depth");
property p_idle;
    idl |-> ##1 (!memRdEn && !memWrEn && $stable(stackPtr)
        && $stable(returnStackTop))[*4];
endproperty
a_idle: assert property(p_idle) else $error("idle side effect");
property p_pcAdv;
    go |-> ##4 pcAdvance;
endproperty
a_pcAdv: assert property(p_pcAdv) else $error("no pc advance");
endmodule
bind negate_nop_stack_ops negate_stack_checker chkI(.*);

// File: test/tb.sv
// Self-checking bench for negate, idle and stack instructions
`timescale 1ns/1ps
module tb;
reg mclk = 0, rst_n = 0, extendedSet = 0;
reg [15:0] nextWord = 0;
reg [20:0] pcIn = 0;
reg [3:0] bankSelectReg = 0;
reg [11:0] indexBase = 12'h200;
reg [7:0] memRdData = 0;
wire instrValid, memRdEn, memWrEn, pcAdvance, busy;
wire [15:0] instrWord;
wire [11:0] memAddr;
wire [7:0] memWrData;
wire [20:0] returnStackTop;
wire [4:0] stackPtr;
integer nErrors = 0, compares = 0, cyc = 0;
fetch_model fm(.mclk(mclk), .rst_n(rst_n), .nextWord(nextWord),
    .instrValid(instrValid), .instrWord(instrWord));
negate_nop_stack_ops dut(.mclk(mclk), .rst_n(rst_n),
    .instrValid(instrValid), .instrWord(instrWord), .pcIn(pcIn),
    .bankSelectReg(bankSelectReg), .extendedSet(extendedSet),
    .indexBase(indexBase), .memRdData(memRdData), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
    .returnStackTop(returnStackTop), .stackPtr(stackPtr),
    .pcAdvance(pcAdvance), .busy(busy));
initial forever #50 mclk = ~mclk;
task chk(input string nm, input [31:0] seen, exp);
    compares = compares + 1;
    if (seen !== exp) begin
        nErrors = nErrors + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
endtask
task closeOut;
    $display("compares %0d errors %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
task op(input [15:0] w);
    @(posedge mclk) nextWord <= w;
    do @(posedge mclk); while (!(instrValid === 1'b1 && instrWord === w));
    nextWord <= 16'h0000;
    repeat (4) @(negedge mclk);
    chk("pcAdvance", pcAdvance, 1);
endtask
task neg(input [8:0] af, input x, input [7:0] d, ed, input [11:0] ea);
    @(posedge mclk) begin extendedSet <= x; memRdData <= d; end
    op({7'h36, af});
    chk("memWrEn", memWrEn, 1);
    chk("memWrData", memWrData, ed);
    chk("memAddr", memAddr, ea);
endtask
task stk(input [15:0] w, input [20:0] pc, et, input [4:0] ep);
    @(posedge mclk) pcIn <= pc;
    op(w);
    chk("top", returnStackTop, et);
    chk("depth", stackPtr, ep);
endtask
always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
        nErrors = nErrors + 1;
        closeOut;
    end
end
initial begin
    bankSelectReg = 4'h3;
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    neg(9'h112, 0, 8'h3a, 8'hc6, 12'h312);
    neg(9'h080, 0, 8'h00, 8'h00, 12'hf80);
    neg(9'h020, 0, 8'h7f, 8'h81, 12'h020);
    neg(9'h060, 1, 8'h80, 8'h80, 12'hf60);
    neg(9'h05f, 1, 8'h01, 8'hff, 12'h25f);
    stk(16'h0005, 21'h3458, 21'h345a, 5'd1);
    stk(16'h0005, 21'h0124, 21'h0126, 5'd2);
    stk(16'h0006, 21'h0, 21'h345a, 5'd1);
    stk(16'hf123, 21'h0, 21'h345a, 5'd1);
    stk(16'h0000, 21'h0, 21'h345a, 5'd1);
    closeOut;
end
endmodule
